// ==== ppc_map.svh ====
// Register offsets, reset values and idle read value of the parallel port block
`ifndef PPC_MAP_SVH
`define PPC_MAP_SVH

`define PPC_OFS_P0_LATCH  5'h00
`define PPC_OFS_P1_PINS   5'h01
`define PPC_OFS_P2_LATCH  5'h02
`define PPC_OFS_P8_LATCH  5'h03
`define PPC_OFS_P9_LATCH  5'h04
`define PPC_OFS_DIR0      5'h05
`define PPC_OFS_DIR2      5'h06
`define PPC_OFS_DIR3      5'h07
`define PPC_OFS_DIR4      5'h08
`define PPC_OFS_DIR5      5'h09
`define PPC_OFS_DIR6      5'h0a
`define PPC_OFS_DIR8      5'h0b
`define PPC_OFS_DIR9      5'h0c
`define PPC_OFS_PULL0     5'h0d
`define PPC_OFS_PULL3     5'h0e
`define PPC_OFS_PULL4     5'h0f
`define PPC_OFS_PULL6     5'h10
`define PPC_OFS_PULL8     5'h11
`define PPC_OFS_PULL9     5'h12
`define PPC_OFS_FN3       5'h13
`define PPC_OFS_FN4       5'h14
`define PPC_OFS_FN8       5'h15
`define PPC_OFS_FN9       5'h16
`define PPC_OFS_IRQ_STAT  5'h17
`define PPC_OFS_IRQ_MASK  5'h18

`define PPC_DIR_RST       8'hff
`define PPC_LATCH_RST     8'h00
`define PPC_NIB_LATCH_RST 4'h0
`define PPC_PU_RST        8'h00
`define PPC_FN_RST        8'h00
`define PPC_MASK_RST      4'hf
`define PPC_STAT_RST      4'h0
`define PPC_RDATA_IDLE    8'h00

`endif

// ==== ppc_pkg.sv ====
// Shared types of the parallel port block
package ppc_pkg;
	typedef logic [7:0] ppc_byte_t;
	typedef logic [4:0] ppc_addr_t;
	typedef logic [3:0] ppc_nib_t;
endpackage

// ==== ppc_sync.sv ====
// Two-flop synchroniser for pin inputs
`timescale 1ns/10ps
`default_nettype none
module ppc_sync #(
	parameter int W = 8
) (
	input  wire logic         clock,
	input  wire logic         nrst,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	logic [W-1:0] stage1;

	// First stage feeds only the second stage
	always_ff @(posedge clock) begin
		if (!nrst) begin
			stage1   <= '0;
			sync_out <= '0;
		end else begin
			stage1   <= async_in;
			sync_out <= stage1;
		end
	end
endmodule
`default_nettype wire

// ==== ppc_pin_mux.sv ====
// Per-bit drive, pull-up and read-back selection of one bidirectional port
`timescale 1ns/10ps
`default_nettype none
module ppc_pin_mux #(
	parameter int W = 8
) (
	input  wire logic [W-1:0] dir_in,
	input  wire logic [W-1:0] latch,
	input  wire logic [W-1:0] alt_en,
	input  wire logic [W-1:0] alt_val,
	input  wire logic [W-1:0] pin_sync,
	input  wire logic [W-1:0] pu_sel,
	output logic      [W-1:0] pin_out,
	output logic      [W-1:0] pin_oe,
	output logic      [W-1:0] pull_en,
	output logic      [W-1:0] rd_val
);
	logic [W-1:0] sense;

	// Direction bit 1 means input with the driver off, unless alt_en drives the bit
	assign pin_out = (alt_en & alt_val) | (~alt_en & latch);
	assign pin_oe  = alt_en | ~dir_in;
	// Pull-up only makes sense on a pin nobody drives from inside
	assign pull_en = pu_sel & dir_in & ~alt_en;
	assign sense   = dir_in | alt_en;
	assign rd_val  = (sense & pin_sync) | (~sense & latch);
endmodule
`default_nettype wire

// ==== ppc_top.sv ====
// Parallel port pin control: registers, pin drive and port zero interrupt flags
`timescale 1ns/10ps
`default_nettype none
`include "ppc_map.svh"
module ppc_top (
	input  wire logic             clock,
	input  wire logic             nrst,
	input  wire ppc_pkg::ppc_addr_t addr,
	input  wire ppc_pkg::ppc_byte_t wdata,
	input  wire logic             wr,
	input  wire logic             rd,
	output ppc_pkg::ppc_byte_t    rdata,
	output logic                  irq,
	input  wire logic [3:0]       quad_io_pins_in,
	output logic      [3:0]       quad_io_pins_out,
	output logic      [3:0]       quad_io_pins_oe,
	output logic      [3:0]       quad_pullup_en,
	input  wire logic [4:0]       analog_shared_inputs,
	output logic      [7:0]       meter_output_pins_out,
	output logic      [7:0]       meter_output_pins_oe,
	input  wire logic [7:0]       meter_pwm,
	input  wire logic [7:0]       segment_io_pins_a_in,
	output logic      [7:0]       segment_io_pins_a_out,
	output logic      [7:0]       segment_io_pins_a_oe,
	output logic      [7:0]       segment_a_pullup_en,
	input  wire logic [7:0]       segment_drive_a,
	input  wire logic [7:0]       segment_io_pins_b_in,
	output logic      [7:0]       segment_io_pins_b_out,
	output logic      [7:0]       segment_io_pins_b_oe,
	output logic      [7:0]       segment_b_pullup_en,
	input  wire logic [7:0]       segment_drive_b,
	output ppc_pkg::ppc_byte_t    dir_sel_p3,
	output ppc_pkg::ppc_byte_t    dir_sel_p4,
	output ppc_pkg::ppc_byte_t    dir_sel_p5,
	output ppc_pkg::ppc_byte_t    dir_sel_p6,
	output ppc_pkg::ppc_byte_t    weak_pullup_sel_p3,
	output ppc_pkg::ppc_byte_t    weak_pullup_sel_p4,
	output ppc_pkg::ppc_byte_t    weak_pullup_sel_p6,
	output ppc_pkg::ppc_byte_t    segment_function_sel_p3,
	output ppc_pkg::ppc_byte_t    segment_function_sel_p4
);
	ppc_pkg::ppc_nib_t  p0_latch;
	ppc_pkg::ppc_byte_t meter_latch;
	ppc_pkg::ppc_byte_t seg_latch_a;
	ppc_pkg::ppc_byte_t seg_latch_b;
	ppc_pkg::ppc_byte_t dir_sel_port_zero;
	ppc_pkg::ppc_byte_t dir_sel_p2;
	ppc_pkg::ppc_byte_t dir_sel_p8;
	ppc_pkg::ppc_byte_t dir_sel_p9;
	ppc_pkg::ppc_byte_t weak_pullup_sel_port_zero;
	ppc_pkg::ppc_byte_t weak_pullup_sel_p8;
	ppc_pkg::ppc_byte_t weak_pullup_sel_p9;
	ppc_pkg::ppc_byte_t segment_function_sel_p8;
	ppc_pkg::ppc_byte_t segment_function_sel_p9;
	ppc_pkg::ppc_nib_t  irq_stat;
	ppc_pkg::ppc_nib_t  irq_mask;
	ppc_pkg::ppc_nib_t  p0_level;
	ppc_pkg::ppc_nib_t  p0_prev;
	ppc_pkg::ppc_nib_t  p0_event;
	ppc_pkg::ppc_nib_t  p0_rd;
	ppc_pkg::ppc_nib_t  quad_sync;
	logic [4:0]         ana_sync;
	logic [7:0]         seg_sync_a;
	logic [7:0]         seg_sync_b;
	logic [7:0]         seg_rd_a;
	logic [7:0]         seg_rd_b;
	logic [24:0]        pins_sync;
	logic               armed;
	logic               latch_write_strobe;

	// All pin inputs cross into the clock domain together
	ppc_sync #(
		.W(25)
	) u_sync (
		.clock    (clock),
		.nrst     (nrst),
		.async_in ({segment_io_pins_b_in, segment_io_pins_a_in, analog_shared_inputs, quad_io_pins_in}),
		.sync_out (pins_sync)
	);
	assign quad_sync  = pins_sync[3:0];
	assign ana_sync   = pins_sync[8:4];
	assign seg_sync_a = pins_sync[16:9];
	assign seg_sync_b = pins_sync[24:17];

	assign latch_write_strobe = wr && (addr == `PPC_OFS_P0_LATCH || addr == `PPC_OFS_P2_LATCH ||
		addr == `PPC_OFS_P8_LATCH || addr == `PPC_OFS_P9_LATCH);

	// Output latches
	always_ff @(posedge clock) begin
		if (!nrst) begin
			p0_latch    <= `PPC_NIB_LATCH_RST;
			meter_latch <= `PPC_LATCH_RST;
			seg_latch_a <= `PPC_LATCH_RST;
			seg_latch_b <= `PPC_LATCH_RST;
		end else if (latch_write_strobe) begin
			case (addr)
				`PPC_OFS_P0_LATCH: p0_latch <= wdata[3:0];
				`PPC_OFS_P2_LATCH: meter_latch <= wdata;
				`PPC_OFS_P8_LATCH: seg_latch_a <= wdata;
				`PPC_OFS_P9_LATCH: seg_latch_b <= wdata;
				default: ;
			endcase
		end
	end

	// Direction registers, ports 3 to 6 only held for their own pin logic
	always_ff @(posedge clock) begin
		if (!nrst) begin
			dir_sel_port_zero <= `PPC_DIR_RST;
			dir_sel_p2        <= `PPC_DIR_RST;
			dir_sel_p3        <= `PPC_DIR_RST;
			dir_sel_p4        <= `PPC_DIR_RST;
			dir_sel_p5        <= `PPC_DIR_RST;
			dir_sel_p6        <= `PPC_DIR_RST;
			dir_sel_p8        <= `PPC_DIR_RST;
			dir_sel_p9        <= `PPC_DIR_RST;
		end else if (wr) begin
			case (addr)
				`PPC_OFS_DIR0: dir_sel_port_zero <= wdata;
				`PPC_OFS_DIR2: dir_sel_p2 <= wdata;
				`PPC_OFS_DIR3: dir_sel_p3 <= wdata;
				`PPC_OFS_DIR4: dir_sel_p4 <= wdata;
				`PPC_OFS_DIR5: dir_sel_p5 <= wdata;
				`PPC_OFS_DIR6: dir_sel_p6 <= wdata;
				`PPC_OFS_DIR8: dir_sel_p8 <= wdata;
				`PPC_OFS_DIR9: dir_sel_p9 <= wdata;
				default: ;
			endcase
		end
	end

	// Pull-up and segment function selections
	always_ff @(posedge clock) begin
		if (!nrst) begin
			weak_pullup_sel_port_zero <= `PPC_PU_RST;
			weak_pullup_sel_p3        <= `PPC_PU_RST;
			weak_pullup_sel_p4        <= `PPC_PU_RST;
			weak_pullup_sel_p6        <= `PPC_PU_RST;
			weak_pullup_sel_p8        <= `PPC_PU_RST;
			weak_pullup_sel_p9        <= `PPC_PU_RST;
			segment_function_sel_p3   <= `PPC_FN_RST;
			segment_function_sel_p4   <= `PPC_FN_RST;
			segment_function_sel_p8   <= `PPC_FN_RST;
			segment_function_sel_p9   <= `PPC_FN_RST;
		end else if (wr) begin
			case (addr)
				`PPC_OFS_PULL0: weak_pullup_sel_port_zero <= wdata;
				`PPC_OFS_PULL3: weak_pullup_sel_p3 <= wdata;
				`PPC_OFS_PULL4: weak_pullup_sel_p4 <= wdata;
				`PPC_OFS_PULL6: weak_pullup_sel_p6 <= wdata;
				`PPC_OFS_PULL8: weak_pullup_sel_p8 <= wdata;
				`PPC_OFS_PULL9: weak_pullup_sel_p9 <= wdata;
				`PPC_OFS_FN3: segment_function_sel_p3 <= wdata;
				`PPC_OFS_FN4: segment_function_sel_p4 <= wdata;
				`PPC_OFS_FN8: segment_function_sel_p8 <= wdata;
				`PPC_OFS_FN9: segment_function_sel_p9 <= wdata;
				default: ;
			endcase
		end
	end

	// Port zero: no alternate drive, the read-back and the interrupt input tap the pin in input mode and the latch in output mode
	ppc_pin_mux #(
		.W(4)
	) u_mux_p0 (
		.dir_in   (dir_sel_port_zero[3:0]),
		.latch    (p0_latch),
		.alt_en   (4'h0),
		.alt_val  (4'h0),
		.pin_sync (quad_sync),
		.pu_sel   (weak_pullup_sel_port_zero[3:0]),
		.pin_out  (quad_io_pins_out),
		.pin_oe   (quad_io_pins_oe),
		.pull_en  (quad_pullup_en),
		.rd_val   (p0_rd)
	);

	ppc_pin_mux #(
		.W(8)
	) u_mux_p8 (
		.dir_in   (dir_sel_p8),
		.latch    (seg_latch_a),
		.alt_en   (segment_function_sel_p8),
		.alt_val  (segment_drive_a),
		.pin_sync (seg_sync_a),
		.pu_sel   (weak_pullup_sel_p8),
		.pin_out  (segment_io_pins_a_out),
		.pin_oe   (segment_io_pins_a_oe),
		.pull_en  (segment_a_pullup_en),
		.rd_val   (seg_rd_a)
	);

	ppc_pin_mux #(
		.W(8)
	) u_mux_p9 (
		.dir_in   (dir_sel_p9),
		.latch    (seg_latch_b),
		.alt_en   (segment_function_sel_p9),
		.alt_val  (segment_drive_b),
		.pin_sync (seg_sync_b),
		.pu_sel   (weak_pullup_sel_p9),
		.pin_out  (segment_io_pins_b_out),
		.pin_oe   (segment_io_pins_b_oe),
		.pull_en  (segment_b_pullup_en),
		.rd_val   (seg_rd_b)
	);

	// PWM is ORed onto the latch, so the latch must be zero when PWM is used
	assign meter_output_pins_out = meter_latch | meter_pwm;
	assign meter_output_pins_oe  = ~dir_sel_p2;

	// Interrupt input sees the driven level in output mode, the pin otherwise
	assign p0_level = (dir_sel_port_zero[3:0] & quad_sync) | (~dir_sel_port_zero[3:0] & p0_latch);
	assign p0_event = armed ? (p0_level ^ p0_prev) : 4'h0;

	// Skips only the first cycle, one short of the two-flop synchroniser delay, so a pin already high at reset still raises a flag
	always_ff @(posedge clock) begin
		if (!nrst) begin
			armed   <= 1'b0;
			p0_prev <= 4'h0;
		end else begin
			armed   <= 1'b1;
			p0_prev <= p0_level;
		end
	end

	// A new event wins over a write-one-to-clear in the same cycle
	always_ff @(posedge clock) begin
		if (!nrst) begin
			irq_stat <= `PPC_STAT_RST;
		end else if (wr && addr == `PPC_OFS_IRQ_STAT) begin
			irq_stat <= (irq_stat & ~wdata[3:0]) | p0_event;
		end else begin
			irq_stat <= irq_stat | p0_event;
		end
	end

	// Mask bit 1 blocks the request; all masked out of reset
	always_ff @(posedge clock) begin
		if (!nrst) begin
			irq_mask <= `PPC_MASK_RST;
		end else if (wr && addr == `PPC_OFS_IRQ_MASK) begin
			irq_mask <= wdata[3:0];
		end
	end

	assign irq = |(irq_stat & ~irq_mask);

	// Read data for the cycle after the strobe; unmapped offsets read zero
	always_ff @(posedge clock) begin
		if (!nrst) begin
			rdata <= `PPC_RDATA_IDLE;
		end else if (rd) begin
			case (addr)
				`PPC_OFS_P0_LATCH: rdata <= {4'h0, p0_rd};
				`PPC_OFS_P1_PINS:  rdata <= {3'h0, ana_sync};
				`PPC_OFS_P2_LATCH: rdata <= meter_latch & dir_sel_p2;
				`PPC_OFS_P8_LATCH: rdata <= seg_rd_a;
				`PPC_OFS_P9_LATCH: rdata <= seg_rd_b;
				`PPC_OFS_DIR0:     rdata <= dir_sel_port_zero;
				`PPC_OFS_DIR2:     rdata <= dir_sel_p2;
				`PPC_OFS_DIR3:     rdata <= dir_sel_p3;
				`PPC_OFS_DIR4:     rdata <= dir_sel_p4;
				`PPC_OFS_DIR5:     rdata <= dir_sel_p5;
				`PPC_OFS_DIR6:     rdata <= dir_sel_p6;
				`PPC_OFS_DIR8:     rdata <= dir_sel_p8;
				`PPC_OFS_DIR9:     rdata <= dir_sel_p9;
				`PPC_OFS_PULL0:    rdata <= weak_pullup_sel_port_zero;
				`PPC_OFS_PULL3:    rdata <= weak_pullup_sel_p3;
				`PPC_OFS_PULL4:    rdata <= weak_pullup_sel_p4;
				`PPC_OFS_PULL6:    rdata <= weak_pullup_sel_p6;
				`PPC_OFS_PULL8:    rdata <= weak_pullup_sel_p8;
				`PPC_OFS_PULL9:    rdata <= weak_pullup_sel_p9;
				`PPC_OFS_FN3:      rdata <= segment_function_sel_p3;
				`PPC_OFS_FN4:      rdata <= segment_function_sel_p4;
				`PPC_OFS_FN8:      rdata <= segment_function_sel_p8;
				`PPC_OFS_FN9:      rdata <= segment_function_sel_p9;
				`PPC_OFS_IRQ_STAT: rdata <= {4'h0, irq_stat};
				`PPC_OFS_IRQ_MASK: rdata <= {4'h0, irq_mask};
				default:           rdata <= `PPC_RDATA_IDLE;
			endcase
		end else begin
			rdata <= `PPC_RDATA_IDLE;
		end
	end

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!nrst);

	a_quad_latch_out: assert property (wr && addr == `PPC_OFS_P0_LATCH |=>
		quad_io_pins_out == $past(wdata[3:0])) else $error("port zero latch not driven");
	a_quad_pullup: assert property ((weak_pullup_sel_port_zero[0] && dir_sel_port_zero[0])
		== quad_pullup_en[0]) else $error("port zero pull-up wrong");
	a_quad_reset_in: assert property ($rose(nrst) |-> quad_io_pins_oe == 4'h0)
		else $error("port zero not input after reset");
	a_out_change_flag: assert property ($past(armed) && dir_sel_port_zero[3:0] == 4'h0 &&
		$stable(dir_sel_port_zero) && $changed(p0_latch) |=> irq_stat != 4'h0)
		else $error("output change raised no flag");
	a_masked_quiet: assert property (irq_mask == 4'hf |-> !irq)
		else $error("masked flag reached interrupt");
	a_analog_read: assert property (rd && addr == `PPC_OFS_P1_PINS |=>
		rdata == {3'h0, $past(ana_sync)}) else $error("input-only port read wrong");
	a_meter_hiz: assert property (wr && addr == `PPC_OFS_DIR2 |=>
		meter_output_pins_oe == ~$past(wdata)) else $error("meter pins drive wrong");
	a_meter_reset_hiz: assert property ($rose(nrst) |-> meter_output_pins_oe == 8'h00)
		else $error("meter pins driven after reset");
	a_meter_readback: assert property (rd && addr == `PPC_OFS_P2_LATCH |=>
		rdata == ($past(meter_latch) & $past(dir_sel_p2))) else $error("meter read-back wrong");
	a_seg_a_select: assert property (wr && addr == `PPC_OFS_FN8 |=>
		(segment_io_pins_a_oe & $past(wdata)) == $past(wdata) &&
		((segment_io_pins_a_out ^ segment_drive_a) & $past(wdata)) == 8'h00) else $error("port a segment select ignored");
	a_seg_b_reset_in: assert property ($rose(nrst) |-> segment_io_pins_b_oe == 8'h00)
		else $error("port b not input after reset");
	a_cfg_store: assert property (wr && addr == `PPC_OFS_DIR5 |=> dir_sel_p5 == $past(wdata))
		else $error("port mode register not stored");
	a_mode_reset: assert property ($rose(nrst) |-> dir_sel_p2 == 8'hff && dir_sel_p9 == 8'hff)
		else $error("mode registers not all ones");
	a_mode_drive: assert property (!dir_sel_p8[7] && !segment_function_sel_p8[7] |->
		segment_io_pins_a_oe[7] && segment_io_pins_a_out[7] == seg_latch_a[7])
		else $error("output mode not driving latch");

	c_flag_irq: cover property (irq_mask != 4'hf ##1 irq);
	c_meter_drive: cover property ($fell(dir_sel_p2[0]) ##1 meter_output_pins_oe[0]);
	c_seg_mode: cover property (segment_function_sel_p9 != 8'h00 && rd && addr == `PPC_OFS_P9_LATCH);
endmodule
`default_nettype wire

// ==== ppc_pin_model.sv ====
// Pin model: external drivers, pull-ups and floating lines of one port
`timescale 1ns/10ps
`default_nettype none
module ppc_pin_model #(
	parameter int W = 8
) (
	input  wire logic         clock,
	input  wire logic [W-1:0] dev_out,
	input  wire logic [W-1:0] dev_oe,
	input  wire logic [W-1:0] pull_en,
	input  wire logic [W-1:0] ext_val,
	input  wire logic [W-1:0] ext_en,
	output logic      [W-1:0] level
);
	logic [W-1:0] last = '0;
	// An undriven line without pull-up flips every cycle, so a stale value never reads as valid
	always_comb begin
		for (int i = 0; i < W; i++) begin
			if (dev_oe[i])
				level[i] = dev_out[i];
			else if (ext_en[i])
				level[i] = ext_val[i];
			else if (pull_en[i])
				level[i] = 1'b1;
			else
				level[i] = ~last[i];
		end
	end
	always_ff @(posedge clock) begin
		last <= level;
	end
endmodule
`default_nettype wire

// ==== parallel_port_pin_control_tb.sv ====
// Self-checking testbench of the parallel port block
`timescale 1ns/10ps
`default_nettype none
module parallel_port_pin_control_tb;
	logic               clock = 1'b0;
	logic               nrst = 1'b0;
	ppc_pkg::ppc_addr_t addr = 5'h00;
	ppc_pkg::ppc_byte_t wdata = 8'h00;
	logic               wr = 1'b0;
	logic               rd = 1'b0;
	ppc_pkg::ppc_byte_t rdata;
	logic               irq;
	logic [3:0]         q_out, q_oe, q_pu, q_lvl;
	logic [3:0]         q_ext_val = 4'h0;
	logic [3:0]         q_ext_en = 4'hf;
	logic [4:0]         analog = 5'h00;
	logic [7:0]         m_out, m_oe;
	logic [7:0]         pwm = 8'h00;
	logic [7:0]         a_out, a_oe, a_pu, a_lvl, b_out, b_oe, b_pu, b_lvl;
	logic [7:0]         seg_a = 8'h00;
	logic [7:0]         seg_b = 8'h00;
	logic [7:0]         ext_ab = 8'h55;
	ppc_pkg::ppc_byte_t d3, d4, d5, d6, u3, u4, u6, f3, f4;
	int                 err_count = 0;
	int                 n_compared = 0;
	int                 cycles = 0;

	always #10 clock = ~clock;

	ppc_top ppc_top_inst (.clock(clock), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .irq(irq), .quad_io_pins_in(q_lvl), .quad_io_pins_out(q_out),
		.quad_io_pins_oe(q_oe), .quad_pullup_en(q_pu), .analog_shared_inputs(analog),
		.meter_output_pins_out(m_out), .meter_output_pins_oe(m_oe), .meter_pwm(pwm),
		.segment_io_pins_a_in(a_lvl), .segment_io_pins_a_out(a_out), .segment_io_pins_a_oe(a_oe),
		.segment_a_pullup_en(a_pu), .segment_drive_a(seg_a), .segment_io_pins_b_in(b_lvl),
		.segment_io_pins_b_out(b_out), .segment_io_pins_b_oe(b_oe), .segment_b_pullup_en(b_pu),
		.segment_drive_b(seg_b), .dir_sel_p3(d3), .dir_sel_p4(d4), .dir_sel_p5(d5), .dir_sel_p6(d6),
		.weak_pullup_sel_p3(u3), .weak_pullup_sel_p4(u4), .weak_pullup_sel_p6(u6),
		.segment_function_sel_p3(f3), .segment_function_sel_p4(f4));
	ppc_pin_model #(.W(4)) ppc_pin_model_inst (.clock(clock), .dev_out(q_out), .dev_oe(q_oe),
		.pull_en(q_pu), .ext_val(q_ext_val), .ext_en(q_ext_en), .level(q_lvl));
	ppc_pin_model #(.W(8)) ppc_pin_model_a_inst (.clock(clock), .dev_out(a_out), .dev_oe(a_oe),
		.pull_en(a_pu), .ext_val(ext_ab), .ext_en(8'hff), .level(a_lvl));
	ppc_pin_model #(.W(8)) ppc_pin_model_b_inst (.clock(clock), .dev_out(b_out), .dev_oe(b_oe),
		.pull_en(b_pu), .ext_val(ext_ab), .ext_en(8'hff), .level(b_lvl));

	task automatic give_verdict;
		$display("Compared %0d, mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Strobe is dropped and one idle edge passes, so back-to-back calls never reassign it in one step
	task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clock);
		wr <= 1'b0;
		@(posedge clock);
	endtask

	task automatic rd_chk(input string what, input logic [4:0] a, input logic [7:0] exp);
		rd <= 1'b1;
		addr <= a;
		@(posedge clock);
		rd <= 1'b0;
		#1;
		chk(what, exp, rdata);
	endtask

	task automatic t_reset;
		chk("quad oe", 8'h00, {4'h0, q_oe});
		chk("meter oe", 8'h00, m_oe);
		chk("seg a oe", 8'h00, a_oe);
		chk("seg b oe", 8'h00, b_oe);
		chk("irq", 8'h00, {7'h0, irq});
		for (int i = 5; i <= 12; i++)
			rd_chk("dir reset", 5'(i), 8'hff);
		for (int i = 13; i <= 22; i++)
			rd_chk("pullup/function reset", 5'(i), 8'h00);
		rd_chk("irq mask reset", 5'h18, 8'h0f);
		rd_chk("irq stat reset", 5'h17, 8'h00);
		rd_chk("unmapped", 5'h1f, 8'h00);
	endtask

	task automatic t_port0_out;
		wr_reg(5'h00, 8'h00);
		wr_reg(5'h05, 8'h00);
		wr_reg(5'h17, 8'h0f);
		chk("quad oe", 8'h0f, {4'h0, q_oe});
		wr_reg(5'h00, 8'h05);
		chk("quad out", 8'h05, {4'h0, q_out});
		rd_chk("irq stat", 5'h17, 8'h05);
		chk("irq masked", 8'h00, {7'h0, irq});
		wr_reg(5'h18, 8'h00);
		#1;
		chk("irq unmasked", 8'h01, {7'h0, irq});
		wr_reg(5'h17, 8'h05);
		#1;
		chk("irq cleared", 8'h00, {7'h0, irq});
		rd_chk("latch readback", 5'h00, 8'h05);
		// Mask again before turning back to input, the source switch itself may flag
		wr_reg(5'h18, 8'h0f);
	endtask

	task automatic t_port0_in;
		wr_reg(5'h05, 8'hff);
		wr_reg(5'h0d, 8'h03);
		chk("quad pullup", 8'h03, {4'h0, q_pu});
		chk("quad oe", 8'h00, {4'h0, q_oe});
		q_ext_val <= 4'ha;
		repeat (3) @(posedge clock);
		rd_chk("port0 pins", 5'h00, 8'h0a);
		q_ext_en <= 4'hc;
		repeat (3) @(posedge clock);
		rd_chk("port0 pulled", 5'h00, 8'h0b);
		analog <= 5'h15;
		repeat (3) @(posedge clock);
		rd_chk("input-only pins", 5'h01, 8'h15);
	endtask

	task automatic t_port2;
		wr_reg(5'h02, 8'ha5);
		rd_chk("port2 readback", 5'h02, 8'ha5);
		chk("meter oe", 8'h00, m_oe);
		wr_reg(5'h06, 8'h0f);
		#1;
		chk("meter oe", 8'hf0, m_oe);
		chk("meter out", 8'ha0, m_out & m_oe);
		rd_chk("port2 readback", 5'h02, 8'h05);
		wr_reg(5'h02, 8'h00);
		pwm <= 8'h5a;
		@(posedge clock);
		#1;
		chk("meter pwm", 8'h50, m_out & m_oe);
	endtask

	task automatic t_seg(input bit b);
		logic [4:0] o;
		o = b ? 5'h01 : 5'h00;
		seg_a <= 8'hc3;
		seg_b <= 8'hc3;
		wr_reg(5'h03 + o, 8'h3c);
		wr_reg(5'h0b + o, 8'h0f);
		wr_reg(5'h11 + o, 8'hff);
		wr_reg(5'h15 + o, 8'h03);
		#1;
		chk("seg oe", 8'hf3, b ? b_oe : a_oe);
		chk("seg out", 8'h33, (b ? b_out : a_out) & 8'hf3);
		chk("seg pullup", 8'h0c, b ? b_pu : a_pu);
		repeat (3) @(posedge clock);
		rd_chk("seg read", 5'h03 + o, 8'h37);
	endtask

	task automatic t_far_regs;
		logic [4:0]         ofs [9];
		ppc_pkg::ppc_byte_t got [9];
		ofs = '{5'h07, 5'h08, 5'h09, 5'h0a, 5'h0e, 5'h0f, 5'h10, 5'h13, 5'h14};
		for (int i = 0; i < 9; i++)
			wr_reg(ofs[i], {3'h2, ofs[i]});
		got = '{d3, d4, d5, d6, u3, u4, u6, f3, f4};
		for (int i = 0; i < 9; i++)
			chk("far port register", {3'h2, ofs[i]}, got[i]);
	endtask

	always @(posedge clock) begin
		cycles++;
		if (cycles == 3000) begin
			err_count++;
			give_verdict();
		end
	end

	initial begin
		repeat (5) @(posedge clock);
		nrst <= 1'b1;
		repeat (2) @(posedge clock);
		t_reset();
		t_port0_out();
		t_port0_in();
		t_port2();
		t_seg(1'b0);
		t_seg(1'b1);
		t_far_regs();
		give_verdict();
	end
endmodule
`default_nettype wire
